// ===== ref_ctrl_pkg.sv
// Constants for the reference select, configuration store and output control block.
package ref_ctrl_pkg;

  // Programming register indices and bit positions.
  localparam int unsigned NUM_REGS         = 128;
  localparam logic [6:0]  PRIM_SRC_REG     = 7'h13;
  localparam int unsigned PRIM_SRC_BIT     = 1;
  localparam logic [6:0]  SWITCH_MODE_REG  = 7'h13;
  localparam int unsigned SWITCH_MODE_LSB  = 6;
  localparam logic [6:0]  PIN_CTRL_REG     = 7'd16;
  localparam int unsigned PIN_POL_BIT      = 1;
  localparam int unsigned PIN_FUNC_BIT     = 0;
  localparam logic [6:0]  XIN_TRIM_REG     = 7'h12;
  localparam logic [6:0]  XOUT_TRIM_REG    = 7'h14;
  localparam int unsigned TRIM_LSB         = 2;
  localparam logic [6:0]  ADDR_SEL_REG     = 7'h15;
  localparam int unsigned ADDR_SEL_BIT     = 0;
  localparam logic [6:0]  STAGE_EN_REG     = 7'h30;
  localparam logic [6:0]  DIS_MASK_REG     = 7'h31;
  localparam logic [6:0]  OTP_CTRL_REG     = 7'd114;
  localparam int unsigned SAVE_BIT         = 3;
  localparam int unsigned RESTORE_BIT      = 0;

  // Register reset value and bus addresses.
  localparam logic [7:0]  REG_RESET        = 8'h00;
  localparam logic [6:0]  ADDR_DEFAULT     = 7'h6a;
  localparam logic [6:0]  ADDR_ALTERNATE   = 7'h68;

  // Two-byte command codes.
  localparam logic [7:0]  CMD_SAVE         = 8'h01;
  localparam logic [7:0]  CMD_RESTORE      = 8'h02;

  // Per-output state codes.
  localparam logic [1:0]  OUT_RUN          = 2'h0;
  localparam logic [1:0]  OUT_PARKED       = 2'h1;
  localparam logic [1:0]  OUT_TRISTATE     = 2'h2;
  localparam logic [1:0]  OUT_SHUTDOWN     = 2'h3;

  // Timing.
  localparam int unsigned CLK_PERIOD_PS    = 8000;
  localparam int unsigned BURN_BYTE_NS     = 400;
  localparam int unsigned BURN_BYTE_CYC    = (BURN_BYTE_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned SWITCH_SETTLE_NS = 200;
  localparam int unsigned SWITCH_CYC       = (SWITCH_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {ST_IDLE, ST_RESTORE, ST_SAVE} store_state_t;

endpackage

// ===== ref_ctrl.sv
// Reference input selection, configuration save/restore and output enable control.
`timescale 1ns/10ps
`default_nettype none

module ref_ctrl #(
  parameter int unsigned NUM_OUTPUTS = 4,
  parameter int unsigned BURN_CYC    = ref_ctrl_pkg::BURN_BYTE_CYC
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     input_select_pin_in,
  input  wire logic                     shutdown_enable_pin_in,
  input  wire logic                     reg_wr_en_in,
  input  wire logic [6:0]               reg_addr_in,
  input  wire logic [7:0]               reg_wdata_in,
  input  wire logic [6:0]               reg_rd_addr_in,
  input  wire logic                     cmd_valid_in,
  input  wire logic [7:0]               cmd_code_in,
  output logic [7:0]                    reg_rdata_out,
  output logic [6:0]                    slave_addr_out,
  output logic                          ack_enable_out,
  output logic                          store_busy_out,
  output logic                          config_ready_out,
  output logic                          ref_is_differential_out,
  output logic                          ref_switching_out,
  output logic                          manual_mode_out,
  output logic [5:0]                    xin_cap_trim_out,
  output logic [5:0]                    xout_cap_trim_out,
  output logic                          pll_powerdown_out,
  output logic [2*NUM_OUTPUTS-1:0]      clock_output_state_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release.
  // The raw reset takes hold at once, but its release passes two flops so that
  // no register leaves reset on an edge that the release itself disturbed.

  logic rst_sync1_q;
  logic rst_sync2_q;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end
    else
    begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end

  // Everything below resets on the released copy, never on the raw pin.
  wire rst_n = rst_sync2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Programming registers and the one-time-programmable store.

  logic [7:0] regs_q [ref_ctrl_pkg::NUM_REGS];
  // The store keeps no reset; a blank part reads back zeros until first burned.
  logic [7:0] otp_q  [ref_ctrl_pkg::NUM_REGS];
  // The burned flag belongs to the store and must outlive a reset, or a reset
  // after a burn would restore zeros instead of the saved image.
  logic       otp_burned_q = 1'b0;

  ref_ctrl_pkg::store_state_t state_q;
  logic [6:0]  idx_q;
  logic [15:0] wait_q;
  logic        boot_done_q;

  wire idle      = (state_q == ref_ctrl_pkg::ST_IDLE);
  wire host_wr   = reg_wr_en_in && idle && boot_done_q;
  wire ctrl_wr   = host_wr && (reg_addr_in == ref_ctrl_pkg::OTP_CTRL_REG);
  // Commands arrive only once the host has closed its transfer with a stop.
  wire cmd_ok    = cmd_valid_in && idle && boot_done_q;
  wire cmd_sav   = cmd_ok && (cmd_code_in == ref_ctrl_pkg::CMD_SAVE);
  wire cmd_rst   = cmd_ok && (cmd_code_in == ref_ctrl_pkg::CMD_RESTORE);
  // A save wins when both trigger bits are written in one byte.
  wire start_sav = (ctrl_wr && reg_wdata_in[ref_ctrl_pkg::SAVE_BIT]) || cmd_sav;
  wire start_rst = !start_sav && ((ctrl_wr && reg_wdata_in[ref_ctrl_pkg::RESTORE_BIT]) || cmd_rst);
  wire last_idx  = (idx_q == 7'(ref_ctrl_pkg::NUM_REGS - 1));
  wire byte_done = (wait_q == 16'(BURN_CYC - 1));
  wire [7:0] otp_byte = otp_burned_q ? otp_q[idx_q] : ref_ctrl_pkg::REG_RESET;

  // A restore copies one byte a cycle; a save holds each byte for the burn time,
  // so a save takes far longer and the bus stays busy throughout.
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= ref_ctrl_pkg::ST_RESTORE;
      idx_q       <= 7'h00;
      wait_q      <= 16'h0000;
      boot_done_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ref_ctrl_pkg::ST_IDLE:
        begin
          idx_q  <= 7'h00;
          wait_q <= 16'h0000;
          if (start_sav)
            state_q <= ref_ctrl_pkg::ST_SAVE;
          else if (start_rst)
            state_q <= ref_ctrl_pkg::ST_RESTORE;
        end
        ref_ctrl_pkg::ST_RESTORE:
        begin
          idx_q <= idx_q + 7'h01;
          if (last_idx)
          begin
            state_q     <= ref_ctrl_pkg::ST_IDLE;
            boot_done_q <= 1'b1;
          end
        end
        ref_ctrl_pkg::ST_SAVE:
        begin
          wait_q <= byte_done ? 16'h0000 : wait_q + 16'h0001;
          if (byte_done)
          begin
            idx_q <= idx_q + 7'h01;
            if (last_idx)
              state_q <= ref_ctrl_pkg::ST_IDLE;
          end
        end
        default:
          state_q <= ref_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  // Trigger bits are not stored, so the control byte always reads back idle.
  // The restore path outranks a host write; writes are refused while busy anyway.
  generate
    for (genvar i = 0; i < ref_ctrl_pkg::NUM_REGS; i++)
    begin : g_regs
      always_ff @(posedge clk_in or negedge rst_n)
      begin
        if (!rst_n)
          regs_q[i] <= ref_ctrl_pkg::REG_RESET;
        else if (state_q == ref_ctrl_pkg::ST_RESTORE && idx_q == 7'(i))
          regs_q[i] <= otp_byte;
        else if (host_wr && reg_addr_in == 7'(i) && 7'(i) != ref_ctrl_pkg::OTP_CTRL_REG)
          regs_q[i] <= reg_wdata_in;
      end

      // The store has no reset, like the memory that it stands for.
      always_ff @(posedge clk_in)
      begin
        if (state_q == ref_ctrl_pkg::ST_SAVE && byte_done && idx_q == 7'(i))
          otp_q[i] <= regs_q[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_in)
  begin
    if (state_q == ref_ctrl_pkg::ST_SAVE && byte_done && last_idx)
      otp_burned_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode.
  // Fields are read straight from the register array; the map is fixed in the package.

  wire [7:0] sel_reg   = regs_q[ref_ctrl_pkg::PRIM_SRC_REG];
  wire [7:0] pin_reg   = regs_q[ref_ctrl_pkg::PIN_CTRL_REG];
  wire       prim_bit  = sel_reg[ref_ctrl_pkg::PRIM_SRC_BIT];
  // Only the upper bit of the field matters: both 0x codes are manual.
  wire       sw_mode_hi = regs_q[ref_ctrl_pkg::SWITCH_MODE_REG][ref_ctrl_pkg::SWITCH_MODE_LSB + 1];
  wire       manual    = !sw_mode_hi;
  // Outside manual mode the primary input is always used.
  wire       pick_sec  = manual && input_select_pin_in;
  // The crystal feeds the loop when the primary bit equals the pin, so the pin
  // simply flips the primary choice.
  wire       next_diff = prim_bit ^ pick_sec;
  wire       pol_high  = pin_reg[ref_ctrl_pkg::PIN_POL_BIT];
  wire       func_sd   = pin_reg[ref_ctrl_pkg::PIN_FUNC_BIT];
  // The pin is an enable: away from its active level it stops the outputs,
  // all by shutdown or only those set in the disable mask by parking, as the function bit says.
  wire       pin_off   = pol_high ? !shutdown_enable_pin_in : shutdown_enable_pin_in;
  wire       shutdown  = func_sd && pin_off;
  wire       oe_park   = !func_sd && pin_off;
  wire [7:0] stage_en  = regs_q[ref_ctrl_pkg::STAGE_EN_REG];
  wire [7:0] dis_mask  = regs_q[ref_ctrl_pkg::DIS_MASK_REG];
  wire       addr_alt  = regs_q[ref_ctrl_pkg::ADDR_SEL_REG][ref_ctrl_pkg::ADDR_SEL_BIT];

  // Per-output state, highest priority first: shutdown, stage off, parked, running.
  logic [2*NUM_OUTPUTS-1:0] out_state_d;

  generate
    for (genvar n = 0; n < NUM_OUTPUTS; n++)
    begin : g_out
      assign out_state_d[2*n +: 2] =
        shutdown                   ? ref_ctrl_pkg::OUT_SHUTDOWN :
        !stage_en[n]               ? ref_ctrl_pkg::OUT_TRISTATE :
        (dis_mask[n] && oe_park)   ? ref_ctrl_pkg::OUT_PARKED   :
                                     ref_ctrl_pkg::OUT_RUN;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Glitch-free source change: the new choice is taken only after a settle window.
  // If the wanted source flips back inside the window, the current source is
  // simply kept; the indicator still shows one full window.

  logic       pending_q;
  logic [7:0] settle_q;
  wire        settle_end = (settle_q == 8'(ref_ctrl_pkg::SWITCH_CYC - 1));

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_is_differential_out <= 1'b0;
      ref_switching_out       <= 1'b0;
      pending_q               <= 1'b0;
      settle_q                <= 8'h00;
    end
    else if (!pending_q)
    begin
      settle_q <= 8'h00;
      if (next_diff != ref_is_differential_out)
      begin
        pending_q         <= 1'b1;
        ref_switching_out <= 1'b1;
      end
    end
    else
    begin
      settle_q <= settle_q + 8'h01;
      if (settle_end)
      begin
        ref_is_differential_out <= next_diff;
        ref_switching_out       <= 1'b0;
        pending_q               <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.
  // Acknowledges stop in the cycle a trigger is taken, so no write slips in ahead of the busy flag.

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_out          <= 8'h00;
      slave_addr_out         <= ref_ctrl_pkg::ADDR_DEFAULT;
      ack_enable_out         <= 1'b0;
      store_busy_out         <= 1'b1;
      config_ready_out       <= 1'b0;
      manual_mode_out        <= 1'b1;
      xin_cap_trim_out       <= 6'h00;
      xout_cap_trim_out      <= 6'h00;
      pll_powerdown_out      <= 1'b0;
      clock_output_state_out <= '0;
    end
    else
    begin
      reg_rdata_out          <= (reg_rd_addr_in == ref_ctrl_pkg::OTP_CTRL_REG) ? 8'h00 : regs_q[reg_rd_addr_in];
      slave_addr_out         <= addr_alt ? ref_ctrl_pkg::ADDR_ALTERNATE : ref_ctrl_pkg::ADDR_DEFAULT;
      ack_enable_out         <= idle && !start_sav && !start_rst && boot_done_q;
      store_busy_out         <= !idle || start_sav || start_rst;
      config_ready_out       <= boot_done_q;
      manual_mode_out        <= manual;
      xin_cap_trim_out       <= regs_q[ref_ctrl_pkg::XIN_TRIM_REG][ref_ctrl_pkg::TRIM_LSB +: 6];
      xout_cap_trim_out      <= regs_q[ref_ctrl_pkg::XOUT_TRIM_REG][ref_ctrl_pkg::TRIM_LSB +: 6];
      pll_powerdown_out      <= shutdown;
      clock_output_state_out <= out_state_d;
    end
  end

endmodule

`default_nettype wire

// ===== ref_ctrl_monitor.sv
// Checker of reference select, store sequencing and output control.
`timescale 1ns/10ps
`default_nettype none
module ref_ctrl_monitor #(
  parameter int unsigned NUM_OUTPUTS = 4
) (
  input wire logic                   clk_in,
  input wire logic                   rst_n_in,
  input wire logic                   reg_wr_en_in,
  input wire logic [6:0]             reg_addr_in,
  input wire logic [7:0]             reg_wdata_in,
  input wire logic                   cmd_valid_in,
  input wire logic [7:0]             cmd_code_in,
  input wire logic [6:0]             slave_addr_out,
  input wire logic                   ack_enable_out,
  input wire logic                   store_busy_out,
  input wire logic                   config_ready_out,
  input wire logic                   ref_is_differential_out,
  input wire logic                   ref_switching_out,
  input wire logic                   manual_mode_out,
  input wire logic [5:0]             xin_cap_trim_out,
  input wire logic [5:0]             xout_cap_trim_out,
  input wire logic                   pll_powerdown_out,
  input wire logic [2*NUM_OUTPUTS-1:0] clock_output_state_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Writes only count once boot is done and the store is idle.
  wire wr_ok = reg_wr_en_in && ack_enable_out && config_ready_out;
  sequence s_cmd;
    wr_ok == 1'b0 && config_ready_out && ack_enable_out && cmd_valid_in &&
      (cmd_code_in == ref_ctrl_pkg::CMD_SAVE || cmd_code_in == ref_ctrl_pkg::CMD_RESTORE);
  endsequence
  sequence s_busy_run;
    (store_busy_out && !ack_enable_out) [*8];
  endsequence
  AST_BUSY_NO_ACK: assert property (store_busy_out |-> !ack_enable_out)
    else $error("acknowledge allowed while store busy");
  AST_CMD_RUNS: assert property (s_cmd |=> s_busy_run)
    else $error("command did not start a busy store run");
  AST_ADDR_PAIR: assert property (slave_addr_out == ref_ctrl_pkg::ADDR_DEFAULT ||
    slave_addr_out == ref_ctrl_pkg::ADDR_ALTERNATE)
    else $error("slave address outside the two choices");
  AST_ADDR_SEL: assert property (wr_ok && reg_addr_in == ref_ctrl_pkg::ADDR_SEL_REG |-> ##2 slave_addr_out ==
    ($past(reg_wdata_in[0], 2) ? ref_ctrl_pkg::ADDR_ALTERNATE : ref_ctrl_pkg::ADDR_DEFAULT))
    else $error("slave address does not follow select bit");
  AST_MANUAL: assert property (wr_ok && reg_addr_in == ref_ctrl_pkg::SWITCH_MODE_REG
    |-> ##2 manual_mode_out == !$past(reg_wdata_in[7], 2))
    else $error("manual mode does not follow field upper bit");
  AST_TRIM_XIN: assert property (wr_ok && reg_addr_in == ref_ctrl_pkg::XIN_TRIM_REG
    |-> ##2 xin_cap_trim_out == $past(reg_wdata_in[7:2], 2))
    else $error("input pin trim not taken");
  AST_TRIM_XOUT: assert property (wr_ok && reg_addr_in == ref_ctrl_pkg::XOUT_TRIM_REG
    |-> ##2 xout_cap_trim_out == $past(reg_wdata_in[7:2], 2))
    else $error("output pin trim not taken");
  AST_SRC_GLITCH: assert property ($changed(ref_is_differential_out) |-> $past(ref_switching_out))
    else $error("source changed without settle window");
  AST_SETTLE: assert property ($rose(ref_switching_out) |-> ref_switching_out [*8])
    else $error("settle window too short");
  AST_SHUTDOWN: assert property (pll_powerdown_out
    |-> clock_output_state_out == {NUM_OUTPUTS{ref_ctrl_pkg::OUT_SHUTDOWN}})
    else $error("shutdown does not override every output");
  AST_NO_SD: assert property (!pll_powerdown_out |-> clock_output_state_out[1:0] != ref_ctrl_pkg::OUT_SHUTDOWN)
    else $error("output shut down without global shutdown");
endmodule
bind ref_ctrl ref_ctrl_monitor #(.NUM_OUTPUTS(NUM_OUTPUTS)) mon (.clk_in, .rst_n_in, .reg_wr_en_in,
  .reg_addr_in, .reg_wdata_in, .cmd_valid_in, .cmd_code_in, .slave_addr_out, .ack_enable_out, .store_busy_out,
  .config_ready_out, .ref_is_differential_out, .ref_switching_out, .manual_mode_out, .xin_cap_trim_out,
  .xout_cap_trim_out, .pll_powerdown_out, .clock_output_state_out);
`default_nettype wire

// ===== ref_host_model.sv
// Behavioural bus host that hands decoded writes and commands to the block.
`timescale 1ns/10ps
`default_nettype none
module ref_host_model (
  input  wire logic       clk_in,
  input  wire logic       ack_enable_out,
  output logic            reg_wr_en_in,
  output logic [6:0]      reg_addr_in,
  output logic [7:0]      reg_wdata_in,
  output logic            cmd_valid_in,
  output logic [7:0]      cmd_code_in
);
  initial
  begin
    reg_wr_en_in = 1'b0;
    cmd_valid_in = 1'b0;
    reg_addr_in = 7'h55;
    reg_wdata_in = 8'haa;
    cmd_code_in = 8'h5a;
  end
  // Other users hold off while the slave withholds acknowledges.
  task automatic idle_wait();
    for (int n = 0; n < 5000 && ack_enable_out !== 1'b1; n++) @(negedge clk_in);
  endtask
  // Released lines show the inverse so a stale value never passes for a live one.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    idle_wait();
    @(negedge clk_in);
    {reg_wr_en_in, reg_addr_in, reg_wdata_in} = {1'b1, a, d};
    @(negedge clk_in);
    {reg_wr_en_in, reg_addr_in, reg_wdata_in} = {1'b0, ~a, ~d};
  endtask
  // Waits for acknowledges, then presents the command code for one cycle, then its inverse.
  task automatic cmd(input logic [7:0] c);
    idle_wait();
    @(negedge clk_in);
    {cmd_valid_in, cmd_code_in} = {1'b1, c};
    @(negedge clk_in);
    {cmd_valid_in, cmd_code_in} = {1'b0, ~c};
  endtask
endmodule
`default_nettype wire

// ===== test_ref_input_select_otp_output_control.sv
// Testbench for reference select, configuration store and output control.
`timescale 1ns/10ps
`default_nettype none
module test_ref_input_select_otp_output_control;
  logic clk_in, rst_n_in, input_select_pin_in, shutdown_enable_pin_in, reg_wr_en_in, cmd_valid_in;
  logic ack_enable_out, store_busy_out, config_ready_out, ref_is_differential_out, ref_switching_out;
  logic manual_mode_out, pll_powerdown_out;
  logic [6:0] reg_addr_in, reg_rd_addr_in, slave_addr_out;
  logic [7:0] reg_wdata_in, cmd_code_in, reg_rdata_out, clock_output_state_out;
  logic [5:0] xin_cap_trim_out, xout_cap_trim_out;
  int error_cnt, tests_run;
  ref_ctrl #(.BURN_CYC(2)) DUT (.*);
  ref_host_model host (.*);
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    repeat (3) @(negedge clk_in);
  endtask
  task automatic boot();
    for (int n = 0; n < 1000 && config_ready_out !== 1'b1; n++) @(negedge clk_in);
    settle();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    host.idle_wait();
    @(negedge clk_in);
    reg_rd_addr_in = a;
    settle();
    chk(reg_rdata_out, exp);
  endtask
  function automatic logic [7:0] out_exp(input logic f, p, s, input logic [3:0] st, mk);
    logic [7:0] r;
    for (int n = 0; n < 4; n++)
      r[2*n +: 2] = (f && s != p) ? ref_ctrl_pkg::OUT_SHUTDOWN : !st[n] ? ref_ctrl_pkg::OUT_TRISTATE :
        (mk[n] && s != p) ? ref_ctrl_pkg::OUT_PARKED : ref_ctrl_pkg::OUT_RUN;
    return r;
  endfunction
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end
  initial
  begin
    {rst_n_in, input_select_pin_in, shutdown_enable_pin_in, reg_rd_addr_in} = '0;
    error_cnt = 0;
    tests_run = 0;
    repeat (4) @(negedge clk_in);
    rst_n_in = 1'b1;
    boot();
    chk({1'b0, slave_addr_out}, 8'h6a);
    chk({7'h0, manual_mode_out}, 8'h01);
    chk({7'h0, ack_enable_out}, 8'h01);
    chk({7'h0, config_ready_out}, 8'h01);
    chk(clock_output_state_out, 8'haa);
    host.wr(7'h12, 8'hfc);
    host.wr(7'h14, 8'h0c);
    settle();
    chk({2'h0, xin_cap_trim_out}, 8'h3f);
    chk({2'h0, xout_cap_trim_out}, 8'h03);
    rd(7'd114, 8'h00);
    host.wr(7'h15, 8'h01);
    settle();
    chk({1'b0, slave_addr_out}, 8'h68);
    host.wr(7'h30, 8'h0e);
    host.wr(7'h31, 8'h05);
    for (int i = 0; i < 6; i++)
    begin
      shutdown_enable_pin_in = i[0];
      host.wr(7'd16, {6'h0, i[1], i[2]});
      settle();
      chk(clock_output_state_out, out_exp(i[2], i[1], i[0], 4'he, 4'h5));
      chk({7'h0, pll_powerdown_out}, {7'h0, i[2] & (i[0] != i[1])});
    end
    shutdown_enable_pin_in = 1'b0;
    host.wr(7'd16, 8'h00);
    host.wr(7'h13, 8'h42);
    settle();
    chk({7'h0, ref_switching_out}, 8'h01);
    chk({7'h0, manual_mode_out}, 8'h01);
    repeat (30) @(negedge clk_in);
    chk({7'h0, ref_is_differential_out}, 8'h01);
    input_select_pin_in = 1'b1;
    repeat (33) @(negedge clk_in);
    chk({7'h0, ref_is_differential_out}, 8'h00);
    host.wr(7'h13, 8'h80);
    settle();
    chk({7'h0, manual_mode_out}, 8'h00);
    host.wr(7'h13, 8'h00);
    host.wr(7'h12, 8'ha8);
    host.cmd(ref_ctrl_pkg::CMD_SAVE);
    chk({6'h0, ack_enable_out, store_busy_out}, 8'h01);
    host.wr(7'h12, 8'h00);
    host.wr(7'd114, 8'h01);
    rd(7'h12, 8'ha8);
    host.wr(7'h12, 8'h04);
    host.cmd(ref_ctrl_pkg::CMD_RESTORE);
    rd(7'h12, 8'ha8);
    rst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk({7'h0, store_busy_out}, 8'h01);
    rst_n_in = 1'b1;
    boot();
    rd(7'h12, 8'ha8);
    chk({1'b0, slave_addr_out}, 8'h68);
    close_out();
  end
endmodule
`default_nettype wire
